//--- verilog/crc_pkg.sv
// Constants, register map and carrier types for the comparator and reference control block.
// Assumes a single 10 MHz clock that also serves as the instruction cycle clock.
//
// How it works
// - Waking from sleep leaves the reference control register contents untouched.
// - Any reset disables the reference, disconnects its pin and clears the level code.
// - Level code is five writable bits in the second reference register.
// - Bit 7 of the first reference register enables the ladder, reset zero.
// - Bit 5 of the first reference register connects the ladder to its pin.
// - Bits 3:2 pick ladder top: supply, external pin, fixed reference, reserved.
// - Unimplemented reference register bits ignore writes and read zero.
// - Comparator enable bit runs the comparator; clear means minimum current.
// - Comparator disabled disconnects every comparator input.
// - Two-bit positive select routes one of four sources to non-inverting input.
// - Three-bit negative select routes one source to the inverting input.
// - Result readable in comparator control and mirrored in shared result register.
// - Pin driven only with pin drive set, direction output and comparator enabled.
// - Registered result feeds converter; pin result feeds timer; unregistered polarity-applied result feeds waveform generator.
// - Pin drive overrides port latch regardless of comparator enable.
// - Internal result registered every instruction cycle; pin output passes unlatched with sync off.
// - Polarity zero passes the decision; polarity one inverts it.
// - Speed select one is normal speed, zero low power; resets to zero.
// - Hysteresis bit switches input hysteresis on and off.
// - Port read returns zero for pins configured as analog.
// - Raw decision is high when non-inverting input is above inverting input.
// - With sync on, timer and pin result latch on timer clock falling edge.
// - Event flag sets on enabled rising or falling edges of the result.
// - Positive codes: 00 pin, 01 ladder, 10 fixed reference, 11 ground.
// - Negative codes: 000 pin0, 001 pin1, 110 fixed reference, 111 ground, others reserved.
package crc_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_REF_MAIN = 5'h00;
    localparam logic [4:0] OFF_REF_LEVEL = 5'h04;
    localparam logic [4:0] OFF_CMP_MAIN = 5'h08;
    localparam logic [4:0] OFF_CMP_INPUT = 5'h0C;
    localparam logic [4:0] OFF_SHARED_RESULT = 5'h10;
    localparam logic [4:0] OFF_EVENT_FLAG = 5'h14;
    localparam logic [4:0] OFF_ANALOG_SELECT = 5'h18;
    localparam logic [4:0] OFF_PORT_READ = 5'h1C;

    localparam int REF_EN_BIT = 7;
    localparam int REF_PIN_BIT = 5;
    localparam int REF_SRC_LO = 2;
    localparam logic [7:0] REF_MAIN_MASK = 8'hAC;
    localparam logic [7:0] REF_LEVEL_MASK = 8'h1F;

    localparam logic [7:0] CMP_MAIN_MASK = 8'hB7;
    localparam int CMP_EN_BIT = 7;
    localparam int CMP_RES_BIT = 6;
    localparam int CMP_PIN_BIT = 5;
    localparam int CMP_POL_BIT = 4;
    localparam int CMP_SP_BIT = 2;
    localparam int CMP_HYS_BIT = 1;
    localparam int CMP_SYNC_BIT = 0;
    localparam int CIN_RISE_BIT = 7;
    localparam int CIN_FALL_BIT = 6;
    localparam int CIN_POS_LO = 4;
    localparam logic [7:0] CMP_INPUT_MASK = 8'hF7;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int PORT_W = 6;

    localparam logic [1:0] POS_PIN = 2'h0;
    localparam logic [1:0] POS_LADDER = 2'h1;
    localparam logic [1:0] POS_FIXED = 2'h2;
    localparam logic [1:0] POS_GROUND = 2'h3;
    localparam logic [2:0] NEG_PIN0 = 3'h0;
    localparam logic [2:0] NEG_PIN1 = 3'h1;
    localparam logic [2:0] NEG_FIXED = 3'h6;
    localparam logic [2:0] NEG_GROUND = 3'h7;

    typedef enum logic [1:0] {
        CRC_SRC_SUPPLY = 2'b00,
        CRC_SRC_EXT_PIN = 2'b01,
        CRC_SRC_FIXED = 2'b10,
        CRC_SRC_RESERVED = 2'b11
    } crc_src_t;

    typedef enum logic [0:0] {
        CRC_BUS_IDLE = 1'b0,
        CRC_BUS_ANSWER = 1'b1
    } crc_bus_t;

    typedef struct packed {
        logic enable;
        logic pin_connect;
        crc_src_t top_source;
        logic [4:0] level_code;
    } crc_ladder_t;

    typedef struct packed {
        logic enable;
        logic pos_connect;
        logic [1:0] pos_select;
        logic neg_connect;
        logic [2:0] neg_select;
        logic speed_normal;
        logic hysteresis;
    } crc_analog_t;

    typedef struct packed {
        logic [7:0] ref_main;
        logic [7:0] ref_level;
        logic [7:0] cmp_main;
        logic [7:0] cmp_input;
        logic event_flag;
        logic [PORT_W-1:0] analog_select;
        crc_bus_t bus_state;
        logic [31:0] readdata;
    } crc_state_t;
endpackage

//--- verilog/crc_result_path.sv
// Polarity, instruction-cycle register and timer-synchronised latch of the comparator result.
// Assumes timer_clk_src is a synchronous level sampled on mclk.
`timescale 1ns/10ps
`default_nettype none
module crc_result_path (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic decision,
    input wire logic enable,
    input wire logic invert,
    input wire logic sync_enable,
    input wire logic timer_clk_src,
    output logic result_async,
    output logic result_sync,
    output logic result_ext
);
    typedef struct packed {
        logic result;
        logic timer_prev;
        logic timer_latch;
    } crc_rp_state_t;

    crc_rp_state_t state;
    crc_rp_state_t next_state;
    logic polar;

    // Disabled comparator holds its core at low, so polarity alone sets the output
    assign polar = (enable & decision) ^ invert;
    assign result_async = polar;
    assign result_sync = state.result;
    assign result_ext = sync_enable ? state.timer_latch : polar;

    always_comb begin
        next_state = state;
        next_state.result = polar;
        next_state.timer_prev = timer_clk_src;
        if (state.timer_prev && !timer_clk_src) begin
            next_state.timer_latch = polar;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

//--- verilog/crc_port_read.sv
// Port read path that forces analog-configured pins to read zero.
// Assumes pin levels arrive synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
module crc_port_read #(
    parameter int WIDTH = crc_pkg::PORT_W
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] pin_level,
    input wire logic [WIDTH-1:0] analog_select,
    output logic [WIDTH-1:0] port_value
);
    typedef struct packed {
        logic [WIDTH-1:0] value;
    } crc_pr_state_t;

    crc_pr_state_t state;
    crc_pr_state_t next_state;

    assign port_value = state.value;

    always_comb begin
        next_state.value = pin_level & ~analog_select;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

//--- verilog/crc_top.sv
// Comparator and reference ladder control with an Avalon-MM register slave.
// Assumes mclk is the instruction clock; analog decision and pins are synchronous inputs.
`timescale 1ns/10ps
`default_nettype none
module crc_top #(
    parameter int PORT_W = crc_pkg::PORT_W
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cmp_decision,
    input wire logic timer_clk_src,
    input wire logic pin_direction_bit,
    input wire logic [PORT_W-1:0] pin_level,
    output logic comparator_pin_out,
    output logic comparator_pin_oe,
    output logic comparator_pin_override,
    output logic result_to_converter,
    output logic result_to_first_timer,
    output logic result_to_waveform_gen,
    output logic comparator_event_flag,
    output crc_pkg::crc_ladder_t ladder,
    output crc_pkg::crc_analog_t analog
);
    crc_pkg::crc_state_t state;
    crc_pkg::crc_state_t next_state;
    logic res_async;
    logic res_sync;
    logic res_ext;
    logic res_prev;
    logic [PORT_W-1:0] port_value;
    logic cmp_en;
    logic req;
    logic ack;
    logic wr_lane;
    logic [7:0] wbyte;

    // Merge a write into an 8-bit register, keeping unimplemented bits at zero
    function automatic logic [7:0] merge_byte(input logic [7:0] data, input logic [7:0] mask);
        merge_byte = data & mask;
    endfunction

    function automatic logic [31:0] widen(input logic [7:0] data);
        widen = {24'h000000, data};
    endfunction

    assign cmp_en = state.cmp_main[crc_pkg::CMP_EN_BIT];
    assign req = avs_read | avs_write;
    assign ack = (state.bus_state == crc_pkg::CRC_BUS_ANSWER);
    assign avs_waitrequest = req & ~ack;
    assign avs_readdata = state.readdata;
    assign wr_lane = avs_write & ~ack & avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    crc_result_path u_result (
        .mclk(mclk),
        .nrst(nrst),
        .decision(cmp_decision),
        .enable(cmp_en),
        .invert(state.cmp_main[crc_pkg::CMP_POL_BIT]),
        .sync_enable(state.cmp_main[crc_pkg::CMP_SYNC_BIT]),
        .timer_clk_src(timer_clk_src),
        .result_async(res_async),
        .result_sync(res_sync),
        .result_ext(res_ext)
    );

    crc_port_read #(
        .WIDTH(PORT_W)
    ) u_port (
        .mclk(mclk),
        .nrst(nrst),
        .pin_level(pin_level),
        .analog_select(state.analog_select),
        .port_value(port_value)
    );

    // Previous registered result for edge detection
    logic prev_q;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= res_sync;
        end
    end
    assign res_prev = prev_q;

    // Reference ladder outputs
    always_comb begin
        ladder.enable = state.ref_main[crc_pkg::REF_EN_BIT];
        ladder.pin_connect = state.ref_main[crc_pkg::REF_PIN_BIT];
        ladder.top_source = crc_pkg::crc_src_t'(state.ref_main[crc_pkg::REF_SRC_LO +: 2]);
        ladder.level_code = state.ref_level[4:0];
    end

    // Comparator analog controls
    always_comb begin
        analog.enable = cmp_en;
        analog.pos_select = state.cmp_input[crc_pkg::CIN_POS_LO +: 2];
        analog.neg_select = state.cmp_input[2:0];
        analog.pos_connect = cmp_en;
        analog.neg_connect = cmp_en &&
            (state.cmp_input[2:0] == crc_pkg::NEG_PIN0 ||
             state.cmp_input[2:0] == crc_pkg::NEG_PIN1 ||
             state.cmp_input[2:0] == crc_pkg::NEG_FIXED ||
             state.cmp_input[2:0] == crc_pkg::NEG_GROUND);
        analog.speed_normal = state.cmp_main[crc_pkg::CMP_SP_BIT];
        analog.hysteresis = state.cmp_main[crc_pkg::CMP_HYS_BIT];
    end

    // Pin drive and peripheral routing
    assign comparator_pin_override = state.cmp_main[crc_pkg::CMP_PIN_BIT];
    assign comparator_pin_oe = state.cmp_main[crc_pkg::CMP_PIN_BIT] & ~pin_direction_bit & cmp_en;
    assign comparator_pin_out = res_ext;
    assign result_to_converter = res_sync;
    assign result_to_first_timer = res_ext;
    assign result_to_waveform_gen = res_async;
    assign comparator_event_flag = state.event_flag;

    always_comb begin
        logic rise;
        logic fall;
        logic set_ev;
        rise = 1'b0;
        fall = 1'b0;
        set_ev = 1'b0;
        next_state = state;

        rise = res_sync & ~res_prev;
        fall = ~res_sync & res_prev;
        set_ev = (rise & state.cmp_input[crc_pkg::CIN_RISE_BIT]) |
                 (fall & state.cmp_input[crc_pkg::CIN_FALL_BIT]);

        // Bus answers one cycle after the request is seen
        if (req && !ack) begin
            next_state.bus_state = crc_pkg::CRC_BUS_ANSWER;
        end else begin
            next_state.bus_state = crc_pkg::CRC_BUS_IDLE;
        end

        if (wr_lane) begin
            case (avs_address)
                crc_pkg::OFF_REF_MAIN: begin
                    next_state.ref_main = merge_byte(wbyte, crc_pkg::REF_MAIN_MASK);
                end
                crc_pkg::OFF_REF_LEVEL: begin
                    next_state.ref_level = merge_byte(wbyte, crc_pkg::REF_LEVEL_MASK);
                end
                crc_pkg::OFF_CMP_MAIN: begin
                    next_state.cmp_main = merge_byte(wbyte, crc_pkg::CMP_MAIN_MASK);
                end
                crc_pkg::OFF_CMP_INPUT: begin
                    next_state.cmp_input = merge_byte(wbyte, crc_pkg::CMP_INPUT_MASK);
                end
                crc_pkg::OFF_EVENT_FLAG: begin
                    if (wbyte[0]) begin
                        next_state.event_flag = 1'b0;
                    end
                end
                crc_pkg::OFF_ANALOG_SELECT: begin
                    next_state.analog_select = wbyte[PORT_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Set wins over a clear in the same cycle
        if (set_ev) begin
            next_state.event_flag = 1'b1;
        end

        if (avs_read && !ack) begin
            case (avs_address)
                crc_pkg::OFF_REF_MAIN: begin
                    next_state.readdata = widen(state.ref_main & crc_pkg::REF_MAIN_MASK);
                end
                crc_pkg::OFF_REF_LEVEL: begin
                    next_state.readdata = widen(state.ref_level & crc_pkg::REF_LEVEL_MASK);
                end
                crc_pkg::OFF_CMP_MAIN: begin
                    next_state.readdata = widen({state.cmp_main[7], res_sync, state.cmp_main[5:0]});
                end
                crc_pkg::OFF_CMP_INPUT: begin
                    next_state.readdata = widen(state.cmp_input);
                end
                crc_pkg::OFF_SHARED_RESULT: begin
                    next_state.readdata = widen({7'h00, res_sync});
                end
                crc_pkg::OFF_EVENT_FLAG: begin
                    next_state.readdata = widen({7'h00, state.event_flag});
                end
                crc_pkg::OFF_ANALOG_SELECT: begin
                    next_state.readdata = {{(32 - PORT_W){1'b0}}, state.analog_select};
                end
                crc_pkg::OFF_PORT_READ: begin
                    next_state.readdata = {{(32 - PORT_W){1'b0}}, port_value};
                end
                default: begin
                    next_state.readdata = 32'h00000000;
                end
            endcase
        end
    end

    // Only nrst clears the registers; there is no sleep input, so wake keeps contents
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state.ref_main <= crc_pkg::RESET_BYTE;
            state.ref_level <= crc_pkg::RESET_BYTE;
            state.cmp_main <= crc_pkg::RESET_BYTE;
            state.cmp_input <= crc_pkg::RESET_BYTE;
            state.event_flag <= 1'b0;
            state.analog_select <= '0;
            state.bus_state <= crc_pkg::CRC_BUS_IDLE;
            state.readdata <= 32'h00000000;
        end else begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

//--- test/crc_top_checker.sv
// Checker on the ports of the comparator and reference control top module.
// Assumes it is bound to crc_top and shares its clock and synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module crc_top_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic pin_direction_bit,
    input wire logic comparator_pin_out,
    input wire logic comparator_pin_oe,
    input wire logic comparator_pin_override,
    input wire logic result_to_converter,
    input wire logic result_to_first_timer,
    input wire logic result_to_waveform_gen,
    input wire logic comparator_event_flag,
    input wire crc_pkg::crc_ladder_t ladder,
    input wire crc_pkg::crc_analog_t analog
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    sequence s_pending;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest;
    endsequence
    chk_bus_answer: assert property ($rose(avs_read || avs_write) |-> s_pending ##1 s_answer)
        else $error("bus answer not one cycle late");
    chk_pin_gate: assert property (
        comparator_pin_oe == (comparator_pin_override && !pin_direction_bit && analog.enable))
        else $error("pin drive enable wrong");
    chk_input_cut: assert property (!analog.enable |-> !analog.pos_connect && !analog.neg_connect)
        else $error("inputs connected while disabled");
    chk_cycle_reg: assert property ($past(nrst) |-> result_to_converter == $past(result_to_waveform_gen))
        else $error("converter result not registered once");
    chk_timer_pin: assert property (result_to_first_timer == comparator_pin_out)
        else $error("timer and pin results differ");
    chk_flag_sticky: assert property (
        comparator_event_flag && !(avs_write && avs_address == crc_pkg::OFF_EVENT_FLAG) |=> comparator_event_flag)
        else $error("event flag dropped without clear");
    chk_flag_cause: assert property (
        $rose(comparator_event_flag) |-> $past(result_to_converter) != $past(result_to_converter, 2))
        else $error("event flag without result edge");
    chk_reset_clear: assert property (
        $rose(nrst) |-> ladder == '0 && !analog.enable && !comparator_pin_oe && !comparator_event_flag)
        else $error("state not cleared by reset");
endmodule
`default_nettype wire

//--- test/crc_far_side.sv
// Far side model: analog input levels, their comparison and the timer clock source.
// Assumes the bench sets both levels and starts or stops the timer clock.
`timescale 1ns/10ps
`default_nettype none
module crc_far_side (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic timer_run,
    input wire logic [7:0] vp,
    input wire logic [7:0] vn,
    output logic cmp_decision,
    output logic timer_clk_src
);
    logic dec_q = 1'b0;
    logic tck = 1'b1;
    logic [1:0] phase = 2'h0;
    assign cmp_decision = dec_q;
    assign timer_clk_src = tck;
    always @(posedge mclk) begin
        dec_q <= vp > vn;
        if (!nrst) begin
            tck <= 1'b1;
            phase <= 2'h0;
        end else if (timer_run) begin
            phase <= phase + 2'h1;
            // Clock stands still at its last level while the timer is stopped
            if (phase == 2'h3) begin
                tck <= !tck;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/test_comparator_and_reference_control.sv
// Self-checking bench for the comparator and reference control block.
// Assumes the package, design, far side model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_comparator_and_reference_control;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, q, r;
    logic avs_waitrequest, cmp_decision, timer_clk_src, res;
    logic comparator_pin_out, comparator_pin_oe, comparator_pin_override, result_to_converter;
    logic result_to_first_timer, result_to_waveform_gen, comparator_event_flag;
    logic pin_direction_bit = 1'b0;
    logic timer_run = 1'b0;
    logic [5:0] pin_level = 6'h00;
    logic [7:0] vp = 8'h00;
    logic [7:0] vn = 8'h00;
    logic [7:0] m, c;
    crc_pkg::crc_ladder_t ladder;
    crc_pkg::crc_analog_t analog;
    int seed = 32'h7D20B354;
    int fail_count = 0;
    int tests_run = 0;
    crc_top dut (.mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .cmp_decision, .timer_clk_src, .pin_direction_bit, .pin_level,
        .comparator_pin_out, .comparator_pin_oe, .comparator_pin_override, .result_to_converter,
        .result_to_first_timer, .result_to_waveform_gen, .comparator_event_flag, .ladder, .analog);
    crc_far_side far (.mclk, .nrst, .timer_run, .vp, .vn, .cmp_decision, .timer_clk_src);
    initial begin
        forever #50 mclk = ~mclk;
    end
    task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("Checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        logic w = 1'b1;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        for (int n = 0; w !== 1'b0; n++) begin
            if (n == 20) begin
                check("bus answer", 1'b0, 1'b1);
                conclude();
            end
            @(posedge mclk);
            w = avs_waitrequest;
            q = avs_readdata;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic put(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic get(input string s, input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(s, q, {24'h0, e});
    endtask
    function automatic logic [9:0] exp_analog(input logic [7:0] m, input logic [7:0] c);
        logic nv;
        nv = (c[2:0] <= 3'h1) || (c[2:0] >= 3'h6);
        return {m[7], m[7], c[5:4], m[7] && nv, c[2:0], m[2], m[1]};
    endfunction
    initial begin
        repeat (100000) @(posedge mclk);
        check("run time", 1'b0, 1'b1);
        conclude();
    end
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        pin_level <= 6'h2A;
        @(posedge mclk);
        check("ladder", ladder, 0);
        check("analog", analog, 0);
        for (int i = 0; i < 7; i++) get("reset", 5'(i * 4), 8'h00);
        get("port", 5'h1C, 8'h2A);
        $display("Test reset done");
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            m = {r[7:4], i[1:0], r[1:0]};
            put(5'h00, m);
            put(5'h04, r[15:8]);
            get("ref main", 5'h00, m & 8'hAC);
            get("ref level", 5'h04, r[15:8] & 8'h1F);
            check("ladder", ladder, {m[7], m[5], m[3:2], r[12:8]});
        end
        avs_byteenable <= 4'hE;
        put(5'h04, 8'h0A);
        avs_byteenable <= 4'hF;
        put(5'h06, 8'h15);
        get("unmapped", 5'h06, 8'h00);
        get("ref level", 5'h04, r[15:8] & 8'h1F);
        put(5'h00, 8'h00);
        check("ladder", ladder, {4'h0, r[12:8]});
        $display("Test reference done");
        for (int i = 0; i < 64; i++) begin
            r = $random(seed);
            m = {i[5], r[6:0]};
            c = {r[15:14], i[1:0], r[8], i[4:2]};
            vp <= r[23:16];
            vn <= r[31:24];
            pin_direction_bit <= r[9];
            res = m[7] ? ((r[23:16] > r[31:24]) ^ m[4]) : m[4];
            put(5'h08, m);
            put(5'h0C, c);
            get("cmp main", 5'h08, {m[7], res, m[5:4], 1'b0, m[2:0]});
            get("shared", 5'h10, {7'h0, res});
            get("cmp input", 5'h0C, c & 8'hF7);
            check("analog", analog, exp_analog(m, c));
            check("override", comparator_pin_override, m[5]);
            check("pin oe", comparator_pin_oe, m[5] & !r[9] & m[7]);
            check("waveform", result_to_waveform_gen, res);
        end
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            pin_level <= r[5:0];
            put(5'h18, r[15:8]);
            get("analog sel", 5'h18, {2'h0, r[13:8]});
            get("port", 5'h1C, {2'h0, r[5:0] & ~r[13:8]});
        end
        $display("Test comparator done");
        vp <= 8'h01;
        vn <= 8'h02;
        put(5'h08, 8'h80);
        put(5'h0C, 8'h80);
        put(5'h14, 8'h01);
        get("flag", 5'h14, 8'h00);
        vp <= 8'h03;
        repeat (4) @(posedge mclk);
        check("waveform", result_to_waveform_gen, 1'b1);
        check("pin out", comparator_pin_out, 1'b1);
        get("flag", 5'h14, 8'h01);
        put(5'h0C, 8'h40);
        put(5'h14, 8'h01);
        put(5'h08, 8'h90);
        check("waveform", result_to_waveform_gen, 1'b0);
        get("flag", 5'h14, 8'h01);
        put(5'h14, 8'h01);
        vp <= 8'h00;
        repeat (4) @(posedge mclk);
        get("flag", 5'h14, 8'h00);
        $display("Test event done");
        put(5'h08, 8'hA1);
        timer_run <= 1'b1;
        repeat (20) @(posedge mclk);
        timer_run <= 1'b0;
        vp <= 8'h09;
        repeat (4) @(posedge mclk);
        check("converter", result_to_converter, 1'b1);
        check("pin out", comparator_pin_out, 1'b0);
        check("pin oe", comparator_pin_oe, !pin_direction_bit);
        timer_run <= 1'b1;
        repeat (20) @(posedge mclk);
        check("pin out", comparator_pin_out, 1'b1);
        check("timer", result_to_first_timer, 1'b1);
        put(5'h08, 8'h21);
        check("pin oe", comparator_pin_oe, 1'b0);
        check("override", comparator_pin_override, 1'b1);
        $display("Test sync done");
        put(5'h00, 8'hAC);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        check("ladder", ladder, 0);
        get("ref main", 5'h00, 8'h00);
        $display("Test second reset done");
        conclude();
    end
endmodule
bind crc_top crc_top_checker chk (.mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_waitrequest,
    .pin_direction_bit, .comparator_pin_out, .comparator_pin_oe, .comparator_pin_override,
    .result_to_converter, .result_to_first_timer, .result_to_waveform_gen, .comparator_event_flag,
    .ladder, .analog);
`default_nettype wire
